//--- design/audio_loader_pkg.sv
package audio_loader_pkg;

  localparam int          ADDR_W = 12;

  // Register offsets
  localparam logic [11:0] OFS_PTR_LOW     = 12'h800;
  localparam logic [11:0] OFS_PTR_HIGH    = 12'h801;
  localparam logic [11:0] OFS_BYTE_PORT   = 12'h802;
  localparam logic [11:0] OFS_RUN_CONTROL = 12'h803;
  localparam logic [11:0] OFS_STANDARD    = 12'h808;
  localparam logic [11:0] OFS_PREFERENCE  = 12'h809;
  localparam logic [11:0] OFS_CARRIER     = 12'h80B;

  // loader_run_control fields
  localparam int          RUN_BIT      = 4;
  localparam int          LOAD_EN_BIT  = 3;
  localparam int          INC_RD_BIT   = 2;
  localparam int          MAP_LSB      = 0;
  localparam logic [1:0]  MAP_RAM_EXEC = 2'h3;

  // audio_standard_select fields
  localparam int          STD_LSB     = 0;
  localparam int          SYS_LSB     = 4;
  localparam logic [3:0]  STD_AUTO    = 4'hF;
  localparam logic [3:0]  SYS_WORLD   = 4'hF;
  localparam logic [3:0]  SYS_NO_NICAM = 4'h8;

  // program_preference fields
  localparam int          FAV_LSB     = 0;
  localparam int          SILENCE_BIT = 3;
  localparam int          DEV_LSB     = 4;
  localparam int          DEEMPH_BIT  = 6;

  // carrier_interpretation fields
  localparam int          LOW_CAR_LSB  = 0;
  localparam int          HIGH_CAR_LSB = 3;
  localparam int          INPUT_KIND_BIT = 5;

  // Reset values
  localparam logic [7:0]  RST_RUN_CONTROL = 8'h00;
  localparam logic [7:0]  RST_STANDARD    = 8'h00;
  localparam logic [7:0]  RST_PREFERENCE  = 8'h00;
  localparam logic [7:0]  RST_CARRIER     = 8'h00;
  localparam logic [15:0] RST_POINTER     = 16'h0000;

  // Detection dwell per candidate
  localparam int          CLK_MHZ      = 125;
  localparam int          SEEK_TIME_US = 100;
  localparam int          SEEK_CYCLES  = SEEK_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LVL_FORCED = 2'b00,
    LVL_SYSTEM = 2'b01,
    LVL_WORLD  = 2'b10
  } detect_level_t;

  typedef enum logic [1:0] {
    ST_IDLE        = 2'b00,
    ST_SEEK_NICAM  = 2'b01,
    ST_SEEK_ANALOG = 2'b10,
    ST_LOCKED      = 2'b11
  } seek_state_t;

endpackage : audio_loader_pkg

//--- design/pin_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Output moves only once stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_sync[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : pin_sync3
`default_nettype wire

//--- design/program_ram.sv
`timescale 1ns/1ns
`default_nettype none
module program_ram #(
  parameter int AW = 16
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wr_data,
  output logic      [7:0]    o_rd_data
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_addr] <= i_wr_data;
    end
  end

  // Combinational read; the caller registers it onto the bus
  assign o_rd_data = mem[i_addr];
endmodule : program_ram
`default_nettype wire

//--- design/audio_mcu_download_config.sv
// Overview of operation
// - Pointer advances after each port access while loading is enabled; select bit picks write or read.
// - Map field value three selects RAM execution.
// - Setting the run bit starts the core.
// - Standard 0 to 14 plays forced standard unmuted, no detection.
// - Standard 15 with a system: NICAM first for systems below 8, then analog; mute on loss.
// - Standard and system 15: worldwide detection, redo on carrier loss.
// - Low carrier field: chroma, BTSC, EIAJ, A2-M, auto for codes 0-4.
// - High carrier field: DK, L, auto for codes 0-2.
// - Deviation field: normal, high to 384 kHz, very high to 540 kHz.
// - Favoured program: mono 0-3, stereo 4, dual pairings 5-7.
// - Silence bit set mutes when preferred program is not detected, except under a forced standard.
// - Input kind bit picks modulated IF or AF; FM radio is system 9.
// - De-emphasis bit: 75 us when 0, 50 us when 1.
`timescale 1ns/1ns
`default_nettype none
module audio_mcu_download_config
  import audio_loader_pkg::*;
#(
  parameter int RAM_AW      = 16,
  parameter int SEEK_CYCLES_P = SEEK_CYCLES
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_wr_stb,
  input  wire logic              i_rd_stb,
  output logic      [7:0]        o_rd_data,
  input  wire logic              i_carrier_present,
  input  wire logic              i_foreign_standard,
  input  wire logic              i_nicam_found,
  input  wire logic              i_analog_found,
  input  wire logic              i_preferred_found,
  output logic                   o_core_run,
  output logic      [1:0]        o_execution_map,
  output logic                   o_ram_exec,
  output logic      [1:0]        o_detect_level,
  output logic                   o_try_nicam,
  output logic                   o_try_analog,
  output logic                   o_audio_mute,
  output logic                   o_redetect,
  output logic      [3:0]        o_standard_select,
  output logic      [3:0]        o_system_select,
  output logic      [2:0]        o_low_carrier_meaning,
  output logic      [1:0]        o_high_carrier_meaning,
  output logic                   o_input_signal_kind,
  output logic      [1:0]        o_deviation_range,
  output logic      [2:0]        o_favoured_program,
  output logic                   o_silence_if_unavailable,
  output logic                   o_deemph_constant
);

  initial begin
    if (RAM_AW < 1 || RAM_AW > 16) $error("RAM_AW must be 1..16");
    if (SEEK_CYCLES_P < 2 || SEEK_CYCLES_P > 65535) $error("SEEK_CYCLES_P out of range");
  end

  typedef struct packed {
    logic [15:0]   ptr;
    logic [7:0]    run_ctl;
    logic [7:0]    std_cfg;
    logic [7:0]    pref_cfg;
    logic [7:0]    car_cfg;
    logic [7:0]    rdata;
    seek_state_t   st;
    logic [15:0]   tmr;
    detect_level_t lvl;
    logic          mute;
    logic          redetect;
    logic          carrier_d;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [4:0] sync_w;
  logic       carrier_s;
  logic       foreign_s;
  logic       nicam_s;
  logic       analog_s;
  logic       pref_s;

  pin_sync3 #(.W(5)) u_sync (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    ({i_carrier_present, i_foreign_standard, i_nicam_found,
                  i_analog_found, i_preferred_found}),
    .o_sync     (sync_w)
  );
  assign {carrier_s, foreign_s, nicam_s, analog_s, pref_s} = sync_w;

  logic              ram_we;
  logic [7:0]        ram_q;
  logic              port_wr;
  logic              port_rd;
  logic              load_en;
  logic              inc_rd;
  logic [3:0]        std_f;
  logic [3:0]        sys_f;
  detect_level_t     lvl_w;

  assign load_en = s_r.run_ctl[LOAD_EN_BIT];
  assign inc_rd  = s_r.run_ctl[INC_RD_BIT];
  assign port_wr = i_wr_stb && (i_addr == OFS_BYTE_PORT);
  assign port_rd = i_rd_stb && (i_addr == OFS_BYTE_PORT);
  assign ram_we  = port_wr && load_en;
  assign std_f   = s_r.std_cfg[STD_LSB +: 4];
  assign sys_f   = s_r.std_cfg[SYS_LSB +: 4];

  program_ram #(.AW(RAM_AW)) u_ram (
    .i_core_clk (i_core_clk),
    .i_wr_en    (ram_we),
    .i_addr     (s_r.ptr[RAM_AW-1:0]),
    .i_wr_data  (i_wr_data),
    .o_rd_data  (ram_q)
  );

  always_comb begin
    if (std_f != STD_AUTO) begin
      lvl_w = LVL_FORCED;
    end else if (sys_f == SYS_WORLD) begin
      lvl_w = LVL_WORLD;
    end else begin
      lvl_w = LVL_SYSTEM;
    end
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.redetect  = 1'b0;
    s_nxt.carrier_d = carrier_s;
    s_nxt.lvl       = lvl_w;

    // Register writes
    if (i_wr_stb) begin
      unique case (i_addr)
        OFS_PTR_LOW:     s_nxt.ptr[7:0]  = i_wr_data;
        OFS_PTR_HIGH:    s_nxt.ptr[15:8] = i_wr_data;
        OFS_RUN_CONTROL: s_nxt.run_ctl   = i_wr_data & 8'h1F;
        OFS_STANDARD:    s_nxt.std_cfg   = i_wr_data;
        OFS_PREFERENCE:  s_nxt.pref_cfg  = i_wr_data & 8'h7F;
        OFS_CARRIER:     s_nxt.car_cfg   = i_wr_data & 8'h3F;
        default: ;
      endcase
    end

    // Auto-increment, only while loading is enabled
    if (load_en && ((port_wr && !inc_rd) || (port_rd && inc_rd))) begin
      s_nxt.ptr = s_r.ptr + 16'h0001;
    end

    // Read data, valid only the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (i_rd_stb) begin
      unique case (i_addr)
        OFS_PTR_LOW:     s_nxt.rdata = s_r.ptr[7:0];
        OFS_PTR_HIGH:    s_nxt.rdata = s_r.ptr[15:8];
        OFS_BYTE_PORT:   s_nxt.rdata = ram_q;
        OFS_RUN_CONTROL: s_nxt.rdata = s_r.run_ctl;
        OFS_STANDARD:    s_nxt.rdata = s_r.std_cfg;
        OFS_PREFERENCE:  s_nxt.rdata = s_r.pref_cfg;
        OFS_CARRIER:     s_nxt.rdata = s_r.car_cfg;
        default:         s_nxt.rdata = 8'h00;
      endcase
    end

    // Detection sequencer; idles at forced level, restarts on any change to system or worldwide level
    if (s_r.tmr != 16'h0000) begin
      s_nxt.tmr = s_r.tmr - 16'h0001;
    end
    if (lvl_w == LVL_FORCED) begin
      s_nxt.st  = ST_IDLE;
      s_nxt.tmr = 16'h0000;
    end else if (lvl_w != s_r.lvl) begin
      s_nxt.st  = ST_SEEK_NICAM;
      s_nxt.tmr = 16'(SEEK_CYCLES_P - 1);
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
          s_nxt.st  = ST_SEEK_NICAM;
          s_nxt.tmr = 16'(SEEK_CYCLES_P - 1);
        end
        ST_SEEK_NICAM: begin
          // Systems without NICAM skip straight to the analog try
          if (nicam_s && (lvl_w == LVL_WORLD || sys_f < SYS_NO_NICAM)) begin
            s_nxt.st = ST_LOCKED;
          end else if (s_r.tmr == 16'h0000 ||
                       (lvl_w == LVL_SYSTEM && sys_f >= SYS_NO_NICAM)) begin
            s_nxt.st  = ST_SEEK_ANALOG;
            s_nxt.tmr = 16'(SEEK_CYCLES_P - 1);
          end
        end
        ST_SEEK_ANALOG: begin
          if (analog_s) begin
            s_nxt.st = ST_LOCKED;
          end else if (s_r.tmr == 16'h0000) begin
            s_nxt.st  = ST_SEEK_NICAM;
            s_nxt.tmr = 16'(SEEK_CYCLES_P - 1);
          end
        end
        ST_LOCKED: begin
          if (s_r.carrier_d && !carrier_s && lvl_w == LVL_WORLD) begin
            s_nxt.st       = ST_SEEK_NICAM;
            s_nxt.tmr      = 16'(SEEK_CYCLES_P - 1);
            s_nxt.redetect = 1'b1;
          end
        end
      endcase
    end

    // Mute policy; forced mode plays whatever is demodulated, noise included
    if (lvl_w == LVL_FORCED) begin
      s_nxt.mute = 1'b0;
    end else begin
      s_nxt.mute = !carrier_s || (s_r.st != ST_LOCKED) ||
                   (lvl_w == LVL_SYSTEM && foreign_s) ||
                   (s_r.pref_cfg[SILENCE_BIT] && !pref_s);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r.ptr       <= RST_POINTER;
      s_r.run_ctl   <= RST_RUN_CONTROL;
      s_r.std_cfg   <= RST_STANDARD;
      s_r.pref_cfg  <= RST_PREFERENCE;
      s_r.car_cfg   <= RST_CARRIER;
      s_r.rdata     <= 8'h00;
      s_r.st        <= ST_IDLE;
      s_r.tmr       <= 16'h0000;
      s_r.lvl       <= LVL_FORCED;
      s_r.mute      <= 1'b0;
      s_r.redetect  <= 1'b0;
      s_r.carrier_d <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rd_data                = s_r.rdata;
  assign o_core_run               = s_r.run_ctl[RUN_BIT];
  assign o_execution_map          = s_r.run_ctl[MAP_LSB +: 2];
  assign o_ram_exec               = (s_r.run_ctl[MAP_LSB +: 2] == MAP_RAM_EXEC);
  assign o_detect_level           = s_r.lvl;
  assign o_try_nicam              = (s_r.st == ST_SEEK_NICAM);
  assign o_try_analog             = (s_r.st == ST_SEEK_ANALOG);
  assign o_audio_mute             = s_r.mute;
  assign o_redetect               = s_r.redetect;
  assign o_standard_select        = std_f;
  assign o_system_select          = sys_f;
  assign o_low_carrier_meaning    = s_r.car_cfg[LOW_CAR_LSB +: 3];
  assign o_high_carrier_meaning   = s_r.car_cfg[HIGH_CAR_LSB +: 2];
  assign o_input_signal_kind      = s_r.car_cfg[INPUT_KIND_BIT];
  assign o_deviation_range        = s_r.pref_cfg[DEV_LSB +: 2];
  assign o_favoured_program       = s_r.pref_cfg[FAV_LSB +: 3];
  assign o_silence_if_unavailable = s_r.pref_cfg[SILENCE_BIT];
  assign o_deemph_constant        = s_r.pref_cfg[DEEMPH_BIT];

  property p_inc_on_write;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (port_wr && load_en && !inc_rd) |=> (s_r.ptr == $past(s_r.ptr) + 16'h0001);
  endproperty
  a_inc_on_write: assert property (p_inc_on_write) else $error("no step after write");

  property p_inc_on_read;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (port_rd && load_en && inc_rd && !i_wr_stb) |=>
      (s_r.ptr == $past(s_r.ptr) + 16'h0001);
  endproperty
  a_inc_on_read: assert property (p_inc_on_read) else $error("no step after read");

  property p_hold_on_write_rdmode;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (port_wr && inc_rd) |=> $stable(s_r.ptr);
  endproperty
  a_hold_on_write_rdmode: assert property (p_hold_on_write_rdmode) else $error("bad step");

  property p_ram_exec;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_wr_stb && i_addr == OFS_RUN_CONTROL && i_wr_data[1:0] == 2'h3) |=> o_ram_exec;
  endproperty
  a_ram_exec: assert property (p_ram_exec) else $error("map 3 not RAM exec");

  property p_run_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_wr_stb && i_addr == OFS_RUN_CONTROL) |=> (o_core_run == $past(i_wr_data[4]));
  endproperty
  a_run_start: assert property (p_run_start) else $error("run bit not applied");

  property p_forced_unmuted;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (std_f != STD_AUTO) |=> !o_audio_mute && !o_try_nicam;
  endproperty
  a_forced_unmuted: assert property (p_forced_unmuted) else $error("forced mode muted");

  property p_system_loss_mute;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (lvl_w == LVL_SYSTEM && (!carrier_s || foreign_s)) |=> o_audio_mute;
  endproperty
  a_system_loss_mute: assert property (p_system_loss_mute) else $error("no mute on loss");

  property p_world_redetect;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (s_r.st == ST_LOCKED && lvl_w == LVL_WORLD && s_r.lvl == LVL_WORLD &&
     s_r.carrier_d && !carrier_s) |=> (o_redetect && o_try_nicam);
  endproperty
  a_world_redetect: assert property (p_world_redetect) else $error("no redetect");

  property p_pref_mute;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (lvl_w != LVL_FORCED && s_r.pref_cfg[SILENCE_BIT] && !pref_s) |=> o_audio_mute;
  endproperty
  a_pref_mute: assert property (p_pref_mute) else $error("preferred absent, not muted");

endmodule : audio_mcu_download_config
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import audio_loader_pkg::*;

  logic              i_core_clk = 1'b0;
  logic              i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0]        i_wr_data = '0;
  logic              i_wr_stb = 1'b0;
  logic              i_rd_stb = 1'b0;
  logic              i_carrier_present = 1'b1;
  logic              i_foreign_standard = 1'b0;
  logic              i_nicam_found = 1'b0;
  logic              i_analog_found = 1'b0;
  logic              i_preferred_found = 1'b1;
  logic [7:0]        o_rd_data;
  logic              o_core_run, o_ram_exec, o_try_nicam, o_try_analog, o_audio_mute;
  logic              o_redetect, o_input_signal_kind, o_silence_if_unavailable;
  logic              o_deemph_constant;
  logic [1:0]        o_execution_map, o_detect_level, o_high_carrier_meaning;
  logic [1:0]        o_deviation_range;
  logic [3:0]        o_standard_select, o_system_select;
  logic [2:0]        o_low_carrier_meaning, o_favoured_program;
  int                n_fail = 0;
  int                n_tests = 0;
  logic              hit;
  logic [7:0]        v;

  // Short dwell keeps the detection walk within a few dozen cycles
  audio_mcu_download_config #(.RAM_AW(16), .SEEK_CYCLES_P(8)) uut (
    .i_core_clk, .i_nrst, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
    .i_carrier_present, .i_foreign_standard, .i_nicam_found, .i_analog_found,
    .i_preferred_found, .o_core_run, .o_execution_map, .o_ram_exec, .o_detect_level,
    .o_try_nicam, .o_try_analog, .o_audio_mute, .o_redetect, .o_standard_select,
    .o_system_select, .o_low_carrier_meaning, .o_high_carrier_meaning,
    .o_input_signal_kind, .o_deviation_range, .o_favoured_program,
    .o_silence_if_unavailable, .o_deemph_constant
  );

  always #4 i_core_clk = ~i_core_clk;

  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_stb  <= 1'b1;
    @(posedge i_core_clk);
    i_wr_stb  <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_addr   <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_core_clk);
    i_rd_stb <= 1'b0;
    #1;
    chk(o_rd_data, exp);
  endtask : rdc

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : wait_cyc

  task automatic setd(input logic c, input logic f, input logic n, input logic a,
                      input logic p);
    @(posedge i_core_clk);
    i_carrier_present  <= c;
    i_foreign_standard <= f;
    i_nicam_found      <= n;
    i_analog_found     <= a;
    i_preferred_found  <= p;
  endtask : setd

  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    rdc(OFS_RUN_CONTROL, 8'h00);
    rdc(OFS_STANDARD, 8'h00);
    rdc(OFS_PREFERENCE, 8'h00);
    rdc(OFS_CARRIER, 8'h00);
    rdc(OFS_PTR_HIGH, 8'h00);
    wait_cyc(1);
    chk(o_rd_data, 8'h00);
    // Increment on write, crossing the low byte boundary
    wr(OFS_RUN_CONTROL, 8'h08);
    wr(OFS_PTR_LOW, 8'hFE);
    wr(OFS_PTR_HIGH, 8'h00);
    for (int k = 0; k < 3; k++) wr(OFS_BYTE_PORT, 8'hA0 + 8'(k));
    rdc(OFS_PTR_LOW, 8'h01);
    rdc(OFS_PTR_HIGH, 8'h01);
    // Increment on read: verify the bytes just stored
    // High byte moved past the boundary above, so both halves are reloaded
    wr(OFS_RUN_CONTROL, 8'h0C);
    wr(OFS_PTR_LOW, 8'hFE);
    wr(OFS_PTR_HIGH, 8'h00);
    for (int k = 0; k < 3; k++) rdc(OFS_BYTE_PORT, 8'hA0 + 8'(k));
    rdc(OFS_PTR_HIGH, 8'h01);
    wr(OFS_BYTE_PORT, 8'h5C);
    rdc(OFS_PTR_LOW, 8'h01);
    rdc(OFS_BYTE_PORT, 8'h5C);
    // Port writes are dropped while loading is disabled
    wr(OFS_RUN_CONTROL, 8'h04);
    wr(OFS_PTR_LOW, 8'h01);
    wr(OFS_BYTE_PORT, 8'h77);
    wr(OFS_RUN_CONTROL, 8'h0C);
    rdc(OFS_BYTE_PORT, 8'h5C);
    rdc(OFS_PTR_LOW, 8'h02);
    wr(OFS_RUN_CONTROL, 8'h13);
    wait_cyc(2);
    chk({o_core_run, o_ram_exec, o_execution_map}, 16'h0F);
    rdc(OFS_RUN_CONTROL, 8'h13);
    // Unmapped place reads zero and disturbs nothing
    wr(12'h805, 8'hFF);
    rdc(12'h805, 8'h00);
    rdc(OFS_STANDARD, 8'h00);
    // Field sweep with reserved bits set
    for (int i = 0; i < 8; i++) begin
      v = 8'(i) | 8'((i % 3) << 4) | {1'b1, i[1], 2'b00, i[0], 3'b000};
      wr(OFS_PREFERENCE, v);
      wr(OFS_CARRIER, 8'hC0 | 8'(i % 5) | 8'((i % 3) << 3) | {2'b00, i[0], 5'h00});
      rdc(OFS_PREFERENCE, v & 8'h7F);
      rdc(OFS_CARRIER, 8'(i % 5) | 8'((i % 3) << 3) | {2'b00, i[0], 5'h00});
      chk({o_favoured_program, o_deviation_range, o_silence_if_unavailable},
          16'((i << 3) | ((i % 3) << 1) | (i & 1)));
      chk({o_deemph_constant, o_input_signal_kind}, 16'({i[1], i[0]}));
      chk({o_low_carrier_meaning, o_high_carrier_meaning}, 16'(((i % 5) << 2) | (i % 3)));
    end
    wr(OFS_PREFERENCE, 8'h00);
    // System level without a NICAM candidate
    setd(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(OFS_STANDARD, 8'h8F);
    wait_cyc(4);
    chk({o_detect_level, o_try_nicam, o_try_analog, o_audio_mute}, 16'h0B);
    setd(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wait_cyc(10);
    chk(o_audio_mute, 1'b0);
    setd(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    wait_cyc(8);
    chk(o_audio_mute, 1'b1);
    wr(OFS_PREFERENCE, 8'h08);
    setd(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cyc(8);
    chk(o_audio_mute, 1'b1);
    setd(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wait_cyc(8);
    chk(o_audio_mute, 1'b0);
    setd(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    wait_cyc(8);
    chk({o_audio_mute, o_redetect}, 16'h2);
    // Worldwide: NICAM then analog, redetect on carrier loss
    setd(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(OFS_STANDARD, 8'hFF);
    wait_cyc(4);
    chk({o_detect_level, o_try_nicam, o_try_analog}, 16'h0A);
    wait_cyc(9);
    chk({o_try_nicam, o_try_analog}, 16'h1);
    setd(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    wait_cyc(24);
    chk(o_audio_mute, 1'b0);
    setd(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    hit = 1'b0;
    for (int k = 0; k < 20 && !hit; k++) begin
      wait_cyc(1);
      hit = (o_redetect === 1'b1);
    end
    chk(hit, 1'b1);
    if (!hit) finish_test();
    // FM radio by system, then forced standard with no carrier
    wr(OFS_STANDARD, 8'h9F);
    wait_cyc(2);
    chk({o_detect_level, o_system_select}, 16'h19);
    wr(OFS_STANDARD, 8'h4A);
    wait_cyc(8);
    chk({o_detect_level, o_audio_mute, o_standard_select, o_system_select}, 16'h0A4);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
